// ==== rtl/rio_consts.svh ====
// Constants of the remote I/O maintenance and status block.
// Assumes inclusion by bare name from every file that needs a figure.
`ifndef RIO_CONSTS_SVH
`define RIO_CONSTS_SVH

// Register bus
`define RIO_ADDR_W 8
`define RIO_DATA_W 32
`define RIO_OFF_CTRL 8'h00
`define RIO_OFF_STATUS 8'h04
`define RIO_OFF_IRQ_STAT 8'h08
`define RIO_OFF_IRQ_MASK 8'h0C
`define RIO_OFF_MAINT_SEL 8'h10
`define RIO_OFF_MAINT_DATA 8'h14
`define RIO_CTRL_EN_BIT 0
`define RIO_CTRL_RESET 1'h0
`define RIO_IRQ_MASK_RESET 4'h0

// Event bits of the interrupt status
`define RIO_EV_W 4
`define RIO_EV_CTRL_CLR 0
`define RIO_EV_ROBOT_CLR 1
`define RIO_EV_RESERVED 2
`define RIO_EV_ERROR 3

// Default output bit positions
`define RIO_OUT_W 6
`define RIO_BIT_READY 0
`define RIO_BIT_RUNNING 1
`define RIO_BIT_PAUSED 2
`define RIO_BIT_ERROR 3
`define RIO_BIT_SAFEGUARD 5

// Part codes
`define RIO_SEL_W 4
`define RIO_CODE_BATTERY 4'h1
`define RIO_ROBOT_FIRST 4'h1
`define RIO_ROBOT_LAST 4'h6

// Maintenance store
`define RIO_MEM_AW 5
`define RIO_MEM_DW 16
`define RIO_MEM_ZERO 16'h0000

`endif

// ==== rtl/rio_edge_sync.sv ====
// Two-flop synchroniser for a trigger pin and its select lines, plus
// an off-to-on detector on the synchronised trigger.
// Assumes the pins are asynchronous to clk_sys_in.
`timescale 1ns/1ps

module rio_edge_sync
  import rio_pkg::*;
(
  input wire logic clk_sys_in,
  input wire logic rst_in,
  input wire logic trig_in,
  input wire rio_part_t sel_in,
  output logic rise_out,
  output rio_part_t sel_out
);

  logic trig_meta;
  logic trig_sync;
  logic trig_prev;
  rio_part_t sel_meta;

  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      trig_meta <= 1'b0;
      trig_sync <= 1'b0;
      trig_prev <= 1'b0;
      sel_meta <= '0;
      sel_out <= '0;
    end else begin
      trig_meta <= trig_in;
      trig_sync <= trig_meta;
      trig_prev <= trig_sync;
      sel_meta <= sel_in;
      sel_out <= sel_meta;
    end
  end

  assign rise_out = trig_sync & ~trig_prev;

endmodule : rio_edge_sync

// ==== rtl/rio_maint_mem.sv ====
// Maintenance information store, one word per part, registered read.
// Assumes one clock; the store takes no reset and keeps its words through rst_in.
`timescale 1ns/1ps
`include "rio_consts.svh"

module rio_maint_mem
  import rio_pkg::*;
(
  input wire logic clk_sys_in,
  rio_mem_if.store mem
);

  rio_word_t store [0:(1<<`RIO_MEM_AW)-1];

  always_ff @(posedge clk_sys_in) begin
    if (mem.we) begin
      store[mem.waddr] <= mem.wdata;
    end
  end

  always_ff @(posedge clk_sys_in) begin
    mem.rdata <= store[mem.raddr];
  end

endmodule : rio_maint_mem

// ==== rtl/rio_mem_if.sv ====
// Port bundle between the top and the maintenance store.
// Assumes one clock shared by both ends.
`timescale 1ns/1ps

interface rio_mem_if;
  import rio_pkg::*;
  logic we;
  rio_addr_t waddr;
  rio_word_t wdata;
  rio_addr_t raddr;
  rio_word_t rdata;
  modport master (output we, output waddr, output wdata, output raddr, input rdata);
  modport store (input we, input waddr, input wdata, input raddr, output rdata);
endinterface : rio_mem_if

// ==== rtl/rio_pkg.sv ====
// Types of the remote I/O maintenance and status block.
// Assumes rio_consts.svh is on the include path.
`include "rio_consts.svh"

package rio_pkg;

  typedef logic [`RIO_SEL_W-1:0] rio_part_t;
  typedef logic [`RIO_MEM_AW-1:0] rio_addr_t;
  typedef logic [`RIO_MEM_DW-1:0] rio_word_t;

  typedef enum logic [`RIO_SEL_W-1:0] {
    RIO_RB_BATTERY = 4'h1,
    RIO_RB_BELT = 4'h2,
    RIO_RB_GREASE = 4'h3,
    RIO_RB_MOTOR = 4'h4,
    RIO_RB_GEAR = 4'h5,
    RIO_RB_SPLINE = 4'h6
  } rio_robot_part_t;

endpackage : rio_pkg

// ==== rtl/rio_top.sv ====
// Remote I/O maintenance clear and status output block.
// Assumes status inputs come from logic on clk_sys_in; trigger and
// select pins come from an external host and are synchronised here.
//
// How it works
// - Controller clear trigger erases selected controller part
// - Controller select weights 1,2,4,8; 1 is battery
// - Clear ignores active errors and warnings
// - Robot clear trigger erases selected robot part
// - Robot select weights 1,2,4,8; codes 1 to 6
// - Status outputs always driven, no program needed
// - Ready when started up and no task runs
// - Running while task runs, off when paused
// - Paused when any paused task exists
// - Error holds until reset input recovers
// - Emergency stop output only in stop state
// - Safeguard output on while safeguard open
// - Remote accept output while remote commands accepted
`timescale 1ns/1ps
`include "rio_consts.svh"

module rio_top
  import rio_pkg::*;
(
  input wire logic clk_sys_in,
  input wire logic rst_in,
  input wire logic [`RIO_ADDR_W-1:0] addr_in,
  input wire logic [`RIO_DATA_W-1:0] wr_data_in,
  input wire logic wr_in,
  input wire logic rd_in,
  output logic [`RIO_DATA_W-1:0] rd_data_out,
  output logic irq_out,
  input wire logic controller_part_clear_trigger_in,
  input wire logic [`RIO_SEL_W-1:0] controller_part_select_bit_in,
  input wire logic robot_part_clear_trigger_in,
  input wire logic [`RIO_SEL_W-1:0] robot_part_select_bit_in,
  input wire logic startup_done_in,
  input wire logic task_running_in,
  input wire logic task_paused_in,
  input wire logic error_event_in,
  input wire logic error_reset_in,
  input wire logic estop_state_in,
  input wire logic power_on_in,
  input wire logic safeguard_is_open_in,
  input wire logic auto_mode_in,
  output logic [`RIO_OUT_W-1:0] status_bits_out,
  output logic emergency_stop_active_output_out,
  output logic remote_accept_output_out
);

  ////////////////////////////////////////////////////////////////////////
  // Decode helpers

  function automatic logic ctrl_valid(input rio_part_t code);
    ctrl_valid = (code == `RIO_CODE_BATTERY);
  endfunction : ctrl_valid

  function automatic logic robot_valid(input rio_part_t code);
    robot_valid = (code >= `RIO_ROBOT_FIRST) && (code <= `RIO_ROBOT_LAST);
  endfunction : robot_valid

  function automatic rio_addr_t part_addr(input logic robot, input rio_part_t code);
    part_addr = {robot, code};
  endfunction : part_addr

  ////////////////////////////////////////////////////////////////////////
  // Registers and state

  logic ctrl_enable;
  logic [`RIO_EV_W-1:0] irq_stat;
  logic [`RIO_EV_W-1:0] irq_mask;
  rio_addr_t maint_sel;
  logic error_flag;
  logic error_prev;
  logic ctrl_rise;
  logic robot_rise;
  rio_part_t ctrl_sel;
  rio_part_t robot_sel;
  logic accept;
  logic ctrl_go;
  logic robot_go;
  logic reserved_hit;
  logic sw_wr_data;
  logic [`RIO_EV_W-1:0] next_irq_stat;
  logic [`RIO_EV_W-1:0] events;

  rio_mem_if mem_bus ();

  ////////////////////////////////////////////////////////////////////////
  // Remote input capture and maintenance store

  rio_edge_sync u_ctrl_sync (
    .clk_sys_in(clk_sys_in),
    .rst_in(rst_in),
    .trig_in(controller_part_clear_trigger_in),
    .sel_in(controller_part_select_bit_in),
    .rise_out(ctrl_rise),
    .sel_out(ctrl_sel)
  );

  rio_edge_sync u_robot_sync (
    .clk_sys_in(clk_sys_in),
    .rst_in(rst_in),
    .trig_in(robot_part_clear_trigger_in),
    .sel_in(robot_part_select_bit_in),
    .rise_out(robot_rise),
    .sel_out(robot_sel)
  );

  rio_maint_mem u_mem (
    .clk_sys_in(clk_sys_in),
    .mem(mem_bus.store)
  );

  ////////////////////////////////////////////////////////////////////////
  // Clear command decode

  assign accept = auto_mode_in & ctrl_enable;
  // Error state deliberately not consulted here
  assign ctrl_go = ctrl_rise & remote_accept_output_out & ctrl_valid(ctrl_sel);
  assign robot_go = robot_rise & remote_accept_output_out & robot_valid(robot_sel);
  assign reserved_hit = remote_accept_output_out & ((ctrl_rise & ~ctrl_valid(ctrl_sel)) |
                                  (robot_rise & ~robot_valid(robot_sel)));
  assign sw_wr_data = wr_in & (addr_in == `RIO_OFF_MAINT_DATA);

  // Remote clears win over a software write; controller over robot
  always_comb begin
    mem_bus.we = ctrl_go | robot_go | sw_wr_data;
    mem_bus.wdata = `RIO_MEM_ZERO;
    mem_bus.waddr = maint_sel;
    if (ctrl_go) begin
      mem_bus.waddr = part_addr(1'b0, ctrl_sel);
    end else if (robot_go) begin
      mem_bus.waddr = part_addr(1'b1, robot_sel);
    end else begin
      mem_bus.wdata = wr_data_in[`RIO_MEM_DW-1:0];
    end
  end

  assign mem_bus.raddr = maint_sel;

  ////////////////////////////////////////////////////////////////////////
  // Status outputs

  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      error_flag <= 1'b0;
    end else if (error_event_in) begin
      error_flag <= 1'b1;
    end else if (error_reset_in) begin
      error_flag <= 1'b0;
    end
  end

  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      status_bits_out <= '0;
      emergency_stop_active_output_out <= 1'b0;
      remote_accept_output_out <= 1'b0;
    end else begin
      status_bits_out <= '0;
      status_bits_out[`RIO_BIT_READY] <= startup_done_in & ~task_running_in;
      status_bits_out[`RIO_BIT_RUNNING] <= task_running_in & ~task_paused_in;
      status_bits_out[`RIO_BIT_PAUSED] <= task_paused_in;
      status_bits_out[`RIO_BIT_ERROR] <= error_flag;
      status_bits_out[`RIO_BIT_SAFEGUARD] <= safeguard_is_open_in;
      emergency_stop_active_output_out <= estop_state_in & power_on_in;
      remote_accept_output_out <= accept;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Interrupt events

  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      error_prev <= 1'b0;
    end else begin
      error_prev <= error_flag;
    end
  end

  always_comb begin
    events = '0;
    events[`RIO_EV_CTRL_CLR] = ctrl_go;
    events[`RIO_EV_ROBOT_CLR] = robot_go;
    events[`RIO_EV_RESERVED] = reserved_hit;
    events[`RIO_EV_ERROR] = error_flag & ~error_prev;
    next_irq_stat = irq_stat;
    if (wr_in && addr_in == `RIO_OFF_IRQ_STAT) begin
      next_irq_stat = irq_stat & ~wr_data_in[`RIO_EV_W-1:0];
    end
    next_irq_stat = next_irq_stat | events;
  end

  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      irq_stat <= '0;
    end else begin
      irq_stat <= next_irq_stat;
    end
  end

  assign irq_out = |(irq_stat & irq_mask);

  ////////////////////////////////////////////////////////////////////////
  // Register bus

  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      ctrl_enable <= `RIO_CTRL_RESET;
      irq_mask <= `RIO_IRQ_MASK_RESET;
      maint_sel <= '0;
    end else if (wr_in) begin
      case (addr_in)
        `RIO_OFF_CTRL: ctrl_enable <= wr_data_in[`RIO_CTRL_EN_BIT];
        `RIO_OFF_IRQ_MASK: irq_mask <= wr_data_in[`RIO_EV_W-1:0];
        `RIO_OFF_MAINT_SEL: maint_sel <= wr_data_in[`RIO_MEM_AW-1:0];
        default: ;
      endcase
    end
  end

  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      rd_data_out <= '0;
    end else begin
      rd_data_out <= '0;
      if (rd_in) begin
        case (addr_in)
          `RIO_OFF_CTRL: rd_data_out <= {{(`RIO_DATA_W-1){1'b0}}, ctrl_enable};
          `RIO_OFF_STATUS: rd_data_out <= {{(`RIO_DATA_W-`RIO_OUT_W-2){1'b0}},
                                           remote_accept_output_out,
                                           emergency_stop_active_output_out,
                                           status_bits_out};
          `RIO_OFF_IRQ_STAT: rd_data_out <= {{(`RIO_DATA_W-`RIO_EV_W){1'b0}}, irq_stat};
          `RIO_OFF_IRQ_MASK: rd_data_out <= {{(`RIO_DATA_W-`RIO_EV_W){1'b0}}, irq_mask};
          `RIO_OFF_MAINT_SEL: rd_data_out <= {{(`RIO_DATA_W-`RIO_MEM_AW){1'b0}}, maint_sel};
          `RIO_OFF_MAINT_DATA: rd_data_out <= {{(`RIO_DATA_W-`RIO_MEM_DW){1'b0}}, mem_bus.rdata};
          default: rd_data_out <= '0;
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Checks

  property p_ctrl_clear;
    @(posedge clk_sys_in) disable iff (rst_in)
    ctrl_go |-> mem_bus.we && mem_bus.waddr == {1'b0, `RIO_CODE_BATTERY} && mem_bus.wdata == '0;
  endproperty
  a_ctrl_clear: assert property (p_ctrl_clear) else $error("controller clear missed");

  property p_ctrl_code;
    @(posedge clk_sys_in) disable iff (rst_in)
    (ctrl_rise && ctrl_sel != `RIO_CODE_BATTERY) |-> !ctrl_go;
  endproperty
  a_ctrl_code: assert property (p_ctrl_code) else $error("reserved controller code acted on");

  property p_clear_in_error;
    @(posedge clk_sys_in) disable iff (rst_in)
    (robot_rise && remote_accept_output_out && robot_valid(robot_sel) && error_flag && !ctrl_go) |->
      mem_bus.we && mem_bus.waddr == {1'b1, robot_sel};
  endproperty
  a_clear_in_error: assert property (p_clear_in_error) else $error("clear blocked by error");

  property p_robot_clear;
    @(posedge clk_sys_in) disable iff (rst_in)
    robot_go && !ctrl_go |-> ##1 irq_stat[`RIO_EV_ROBOT_CLR];
  endproperty
  a_robot_clear: assert property (p_robot_clear) else $error("robot clear not flagged");

  property p_robot_code;
    @(posedge clk_sys_in) disable iff (rst_in)
    robot_go |-> robot_sel >= `RIO_ROBOT_FIRST && robot_sel <= `RIO_ROBOT_LAST;
  endproperty
  a_robot_code: assert property (p_robot_code) else $error("robot code out of range");

  property p_run_pause;
    @(posedge clk_sys_in) disable iff (rst_in)
    task_paused_in && !rst_in |=> !status_bits_out[`RIO_BIT_RUNNING] && status_bits_out[`RIO_BIT_PAUSED];
  endproperty
  a_run_pause: assert property (p_run_pause) else $error("running on while paused");

  property p_ready;
    @(posedge clk_sys_in) disable iff (rst_in)
    ##1 ($past(rst_in) ||
         status_bits_out[`RIO_BIT_READY] == ($past(startup_done_in) && !$past(task_running_in)));
  endproperty
  a_ready: assert property (p_ready) else $error("ready output wrong");

  property p_error_hold;
    @(posedge clk_sys_in) disable iff (rst_in)
    (error_flag && !error_reset_in) |=> error_flag ##1 status_bits_out[`RIO_BIT_ERROR];
  endproperty
  a_error_hold: assert property (p_error_hold) else $error("error dropped without reset");

  property p_estop;
    @(posedge clk_sys_in) disable iff (rst_in)
    !power_on_in |=> !emergency_stop_active_output_out;
  endproperty
  a_estop: assert property (p_estop) else $error("stop output on while powered down");

  property p_safeguard;
    @(posedge clk_sys_in) disable iff (rst_in)
    $rose(safeguard_is_open_in) && !rst_in |=> status_bits_out[`RIO_BIT_SAFEGUARD];
  endproperty
  a_safeguard: assert property (p_safeguard) else $error("safeguard output late");

  property p_accept_gate;
    @(posedge clk_sys_in) disable iff (rst_in)
    !remote_accept_output_out |-> !ctrl_go && !robot_go && !reserved_hit;
  endproperty
  a_accept_gate: assert property (p_accept_gate) else $error("trigger taken without accept");

  property p_once;
    @(posedge clk_sys_in) disable iff (rst_in)
    ctrl_go |=> !ctrl_go;
  endproperty
  a_once: assert property (p_once) else $error("controller clear repeated");

endmodule : rio_top

// ==== sim/rio_host_model.sv ====
// Host model driving the clear triggers and part select lines.
// Assumes the bench calls clear_part from its main sequence.
`timescale 1ns/1ps

module rio_host_model (
  input wire logic clk_sys_in,
  output logic ctrl_trig_out,
  output logic [3:0] ctrl_sel_out,
  output logic rb_trig_out,
  output logic [3:0] rb_sel_out
);
  ////////////////////////////////////////////////////////////
  initial begin
    ctrl_trig_out = 1'b0;
    rb_trig_out = 1'b0;
    ctrl_sel_out = 4'h0;
    rb_sel_out = 4'h0;
  end

  // One trigger pulse per call, select set up before and held after
  task automatic clear_part(input bit rb, input logic [3:0] code);
    @(posedge clk_sys_in);
    if (rb) rb_sel_out <= code;
    else ctrl_sel_out <= code;
    @(posedge clk_sys_in);
    if (rb) rb_trig_out <= 1'b1;
    else ctrl_trig_out <= 1'b1;
    repeat (4) @(posedge clk_sys_in);
    rb_trig_out <= 1'b0;
    ctrl_trig_out <= 1'b0;
    repeat (3) @(posedge clk_sys_in);
    // Select released: show the inverse, not the held value
    if (rb) rb_sel_out <= ~code;
    else ctrl_sel_out <= ~code;
    repeat (2) @(posedge clk_sys_in);
  endtask : clear_part
endmodule : rio_host_model

// ==== sim/testbench.sv ====
// Self-checking bench for the remote I/O maintenance and status block.
// Assumes the host model drives the trigger and select pins.
`timescale 1ns/1ps
`include "rio_consts.svh"

module testbench;
  import rio_pkg::*;
  logic clk_sys_in, rst_in, wr, rd, irq, rd_seen, err_exp, en_exp;
  logic [7:0] addr;
  logic [31:0] wdata, rdata;
  logic st_su, st_run, st_pau, err_ev, err_rst, st_es, st_pw, st_sg, st_auto;
  logic [5:0] sbits;
  logic es_out, acc_out, ct, rt;
  logic [3:0] cs, rs;
  logic [6:0] cur_v;
  logic [31:0] exp_q[$];
  int n_errors, checks, cyc;

  rio_top i_dut (.clk_sys_in(clk_sys_in), .rst_in(rst_in), .addr_in(addr), .wr_data_in(wdata),
    .wr_in(wr), .rd_in(rd), .rd_data_out(rdata), .irq_out(irq),
    .controller_part_clear_trigger_in(ct), .controller_part_select_bit_in(cs),
    .robot_part_clear_trigger_in(rt), .robot_part_select_bit_in(rs),
    .startup_done_in(st_su), .task_running_in(st_run), .task_paused_in(st_pau),
    .error_event_in(err_ev), .error_reset_in(err_rst), .estop_state_in(st_es),
    .power_on_in(st_pw), .safeguard_is_open_in(st_sg), .auto_mode_in(st_auto),
    .status_bits_out(sbits), .emergency_stop_active_output_out(es_out),
    .remote_accept_output_out(acc_out));

  rio_host_model i_host (.clk_sys_in(clk_sys_in), .ctrl_trig_out(ct), .ctrl_sel_out(cs),
    .rb_trig_out(rt), .rb_sel_out(rs));

  ////////////////////////////////////////////////////////////
  initial begin
    clk_sys_in = 1'b0;
    forever #20 clk_sys_in = ~clk_sys_in;
  end

  task automatic give_verdict();
    $display("checks %0d errors %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : give_verdict

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  always @(posedge clk_sys_in) begin
    cyc++;
    if (cyc == 5000) begin
      n_errors++;
      give_verdict();
    end
  end

  // Read results are matched against the oldest note
  always @(posedge clk_sys_in) begin
    if (rd_seen) check(rdata, exp_q.pop_front());
    rd_seen <= rd;
  end

  task automatic bus_wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys_in);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk_sys_in);
    wr <= 1'b0;
  endtask : bus_wr

  task automatic bus_rd(input logic [7:0] a, input logic [31:0] e);
    @(posedge clk_sys_in);
    addr <= a;
    rd <= 1'b1;
    exp_q.push_back(e);
    @(posedge clk_sys_in);
    rd <= 1'b0;
  endtask : bus_rd

  task automatic check_irq(input logic e);
    @(negedge clk_sys_in);
    check({31'h0, irq}, {31'h0, e});
  endtask : check_irq

  function automatic logic [31:0] st_exp(input logic [6:0] v);
    return {24'h0, v[6] & en_exp, v[3] & v[4], v[5], 1'b0, err_exp, v[2], v[1] & ~v[2], v[0] & ~v[1]};
  endfunction : st_exp

  task automatic stat_case(input logic [6:0] v);
    @(posedge clk_sys_in);
    {st_auto, st_sg, st_pw, st_es, st_pau, st_run, st_su} <= v;
    cur_v = v;
    @(posedge clk_sys_in);
    bus_rd(`RIO_OFF_STATUS, st_exp(v));
    @(negedge clk_sys_in);
    check({24'h0, acc_out, es_out, sbits}, st_exp(v));
  endtask : stat_case

  task automatic err_pulse(input bit rstp);
    @(posedge clk_sys_in);
    if (rstp) err_rst <= 1'b1;
    else err_ev <= 1'b1;
    @(posedge clk_sys_in);
    err_rst <= 1'b0;
    err_ev <= 1'b0;
    err_exp = !rstp;
  endtask : err_pulse

  task automatic clr_case(input logic [4:0] idx);
    logic [31:0] w;
    logic [3:0] c;
    bit ok, acc;
    logic [31:0] ev;
    w = {16'h0, 16'($urandom()) | 16'h0001};
    c = idx[3:0];
    acc = cur_v[6] & en_exp;
    ok = idx[4] ? (c >= 4'h1 && c <= 4'h6) : (c == `RIO_CODE_BATTERY);
    ev = !acc ? 32'h0 : !ok ? 32'h4 : idx[4] ? 32'h2 : 32'h1;
    bus_wr(`RIO_OFF_MAINT_SEL, {27'h0, idx});
    bus_wr(`RIO_OFF_MAINT_DATA, w);
    i_host.clear_part(idx[4], c);
    bus_rd(`RIO_OFF_MAINT_DATA, (acc && ok) ? 32'h0 : w);
    bus_rd(`RIO_OFF_IRQ_STAT, ev);
    check_irq(ev != 32'h0);
    bus_wr(`RIO_OFF_IRQ_STAT, 32'hF);
  endtask : clr_case

  ////////////////////////////////////////////////////////////
  initial begin
    logic [4:0] tbl[] = '{5'h01, 5'h11, 5'h12, 5'h13, 5'h14, 5'h15, 5'h16,
      5'h00, 5'h02, 5'h0F, 5'h10, 5'h17, 5'h1F};
    void'($urandom(54389));
    rst_in = 1'b1;
    addr = 8'h00;
    wdata = 32'h0;
    {wr, rd, rd_seen, err_exp, en_exp, err_ev, err_rst} = '0;
    {st_auto, st_sg, st_pw, st_es, st_pau, st_run, st_su} = '0;
    cur_v = 7'h00;
    n_errors = 0;
    checks = 0;
    cyc = 0;
    repeat (8) @(posedge clk_sys_in);
    rst_in <= 1'b0;
    foreach (tbl[i]) if (i < 5) bus_rd(8'h00 + 8'(i * 4), 32'h0);
    bus_wr(8'h20, 32'hFFFFFFFF);
    bus_rd(8'h20, 32'h0);
    stat_case(7'h40);
    clr_case(5'h01);
    bus_wr(`RIO_OFF_CTRL, 32'hFFFFFFFF);
    en_exp = 1'b1;
    bus_rd(`RIO_OFF_CTRL, 32'h1);
    repeat (24) stat_case(7'($urandom()));
    err_pulse(1'b0);
    stat_case(7'h11);
    check_irq(1'b0);
    err_pulse(1'b1);
    stat_case(7'h11);
    err_pulse(1'b0);
    bus_wr(`RIO_OFF_IRQ_MASK, 32'hFFFFFFFF);
    bus_rd(`RIO_OFF_IRQ_MASK, 32'hF);
    check_irq(1'b1);
    bus_wr(`RIO_OFF_IRQ_STAT, 32'hF);
    check_irq(1'b0);
    stat_case(7'h41);
    foreach (tbl[i]) clr_case(tbl[i]);
    stat_case(7'h01);
    clr_case(5'h01);
    clr_case(5'h13);
    // Mid-run reset: registers and error state return to idle
    rst_in <= 1'b1;
    en_exp = 1'b0;
    err_exp = 1'b0;
    repeat (2) @(posedge clk_sys_in);
    rst_in <= 1'b0;
    bus_rd(`RIO_OFF_CTRL, 32'h0);
    bus_rd(`RIO_OFF_IRQ_MASK, 32'h0);
    check_irq(1'b0);
    stat_case(7'h21);
    repeat (4) @(posedge clk_sys_in);
    give_verdict();
  end
endmodule : testbench
